// ===== shared/slip_pkg.sv
// constants and carriers for the five-stage slip and interlock control
// assumes one core clock; decode fields follow the 32-bit instruction word
// How it works
// - each clock decide per stage advance; a held stage holds all earlier
// - later stages keep advancing; bubble no-op enters behind held stage
// - held instruction retries every cycle, issues once condition clears
// - icache miss: instruction waits in E, missing word forwarded into E
// - consumer of previous load destination held one extra cycle in E
// - consumer of system-control read destination delayed one cycle in E
// - fast multiply consumer delayed two (16x32) or three (32x32) cycles
// - fast multiply non-consumer delayed one (16x32) or two (32x32) cycles
// - small multiplier: next multiply-divide op waits for first to finish
// - with no interlock one instruction issues per clock
// - access right after translation write uses new entry, no spacing
// - fetch sees new translation entry after three instructions or jump barrier
// - system read after translation read sees updated entries, no spacing
// - fetch sees cache-written code after three instructions or jump barrier
// - compare rewrite clears timer interrupt after four instructions
// - other system-control writes seen after two instructions
// - barriers clear execution hazards; jump barrier plus sync clears fetch
// - execution barrier decoded as variant of the no-op encoding
// - register jumps with hint bit 10 set are hazard barriers
// - icache sync decoded as new encoding in register-immediate group
// - interlocks only hold part of the pipe, never halt it whole
package slip_pkg;
   localparam logic [5:0] OP_SPECIAL  = 6'h00;
   localparam logic [5:0] OP_REG_IMMEDIATE_GROUP   = 6'h01;
   localparam logic [5:0] OP_COP0     = 6'h10;
   localparam logic [5:0] OP_CACHE    = 6'h2f;
   localparam logic [5:0] OP_SPECIAL2 = 6'h1c;
   localparam logic [5:0] FN_JR       = 6'h08;
   localparam logic [5:0] FN_JALR     = 6'h09;
   localparam logic [5:0] FN_SLL      = 6'h00;
   localparam logic [5:0] FN_MUL      = 6'h02;
   localparam logic [4:0] RT_ICACHE_SYNC_OP    = 5'h1f;
   localparam logic [4:0] RS_MF       = 5'h00;
   localparam logic [4:0] RS_MT       = 5'h04;
   localparam logic [5:0] FN_XLAT_READ_OP     = 6'h01;
   localparam logic [5:0] FN_XLAT_WRITE_INDEXED_OP    = 6'h02;
   localparam logic [5:0] FN_XLAT_WRITE_RANDOM_OP    = 6'h06;
   localparam logic [4:0] SA_EXEC_BAR = 5'h03;
   localparam int         HINT_BAR_BIT = 10;
   localparam logic [4:0] CP0_COMPARE = 5'h0b;
   // issue delays in cycles
   localparam logic [1:0] DLY_LOAD     = 2'h1;
   localparam logic [1:0] DLY_SYSREAD  = 2'h1;
   localparam logic [1:0] DLY_MUL16_C  = 2'h2;
   localparam logic [1:0] DLY_MUL32_C  = 2'h3;
   localparam logic [1:0] DLY_MUL16_N  = 2'h1;
   localparam logic [1:0] DLY_MUL32_N  = 2'h2;
   // hazard spacings in instructions
   localparam logic [2:0] SP_XLAT_FETCH = 3'h3;
   localparam logic [2:0] SP_CACHE_FETCH = 3'h3;
   localparam logic [2:0] SP_TIMER      = 3'h4;
   localparam logic [2:0] SP_SYSWRITE   = 3'h2;
   localparam logic [2:0] SP_XLAT_EXEC  = 3'h0;
   localparam logic [2:0] SP_XLAT_READ  = 3'h0;

   typedef struct packed {
      logic       valid;
      logic       is_load;
      logic       sysctl_read_op;
      logic       sysctl_write_op;
      logic       timer_clear;
      logic       reg_multiply_op;
      logic       mdu_op;
      logic       xlat_write_op;
      logic       xlat_read_op;
      logic       cache_op;
      logic       exec_barrier_op;
      logic       jump_barrier_op;
      logic       icache_sync_op;
      logic       mem_op;
      logic       rs_used;
      logic       rt_used;
      logic [4:0] rs;
      logic [4:0] rt;
      logic [4:0] dest;
   } decode_t;

   typedef struct packed {
      logic adv_i;
      logic adv_e;
      logic adv_m;
      logic adv_a;
   } advance_t;
endpackage

// ===== rtl/insn_decode.sv
// decodes one instruction word into the hazard-relevant fields
// assumes the word is valid whenever valid is high
`timescale 1ns/1ns
module insn_decode
(
   input  wire logic             valid,
   input  wire logic [31:0]      word,
   output slip_pkg::decode_t     dec
);
   logic [5:0] op;
   logic [5:0] fn;
   logic [4:0] rs;
   logic [4:0] rt;
   logic [4:0] rd;
   assign op = word[31:26];
   assign fn = word[5:0];
   assign rs = word[25:21];
   assign rt = word[20:16];
   assign rd = word[15:11];

   // field classification
   always_comb
   begin
      dec = '0;
      dec.valid = valid;
      dec.rs = rs;
      dec.rt = rt;
      dec.is_load = valid && (op[5:3] == 3'h4);
      dec.mem_op = valid && (op[5:4] == 2'h2 || op == slip_pkg::OP_CACHE);
      dec.cache_op = valid && op == slip_pkg::OP_CACHE;
      dec.rs_used = valid;
      dec.rt_used = valid && (op == slip_pkg::OP_SPECIAL
                    || op[5:3] == 3'h5 || op == slip_pkg::OP_SPECIAL2);
      if (dec.is_load)
         dec.dest = rt;
      else if (op == slip_pkg::OP_SPECIAL || op == slip_pkg::OP_SPECIAL2)
         dec.dest = rd;
      else
         dec.dest = rt;
      // sll r0,r0,3: still a no-op on older cores
      dec.exec_barrier_op = valid && word[31:11] == 21'h0
                            && word[10:6] == slip_pkg::SA_EXEC_BAR
                            && fn == slip_pkg::FN_SLL;
      dec.jump_barrier_op = valid && op == slip_pkg::OP_SPECIAL
                            && (fn == slip_pkg::FN_JR
                                || fn == slip_pkg::FN_JALR)
                            && word[slip_pkg::HINT_BAR_BIT];
      dec.icache_sync_op = valid && op == slip_pkg::OP_REG_IMMEDIATE_GROUP
                           && rt == slip_pkg::RT_ICACHE_SYNC_OP;
      dec.sysctl_read_op = valid && op == slip_pkg::OP_COP0
                           && rs == slip_pkg::RS_MF;
      dec.sysctl_write_op = valid && op == slip_pkg::OP_COP0
                            && rs == slip_pkg::RS_MT;
      dec.timer_clear = dec.sysctl_write_op && rd == slip_pkg::CP0_COMPARE;
      dec.xlat_write_op = valid && op == slip_pkg::OP_COP0 && word[25]
                          && (fn == slip_pkg::FN_XLAT_WRITE_INDEXED_OP
                              || fn == slip_pkg::FN_XLAT_WRITE_RANDOM_OP);
      dec.xlat_read_op = valid && op == slip_pkg::OP_COP0 && word[25]
                         && fn == slip_pkg::FN_XLAT_READ_OP;
      dec.reg_multiply_op = valid && op == slip_pkg::OP_SPECIAL2
                            && fn == slip_pkg::FN_MUL;
      dec.mdu_op = dec.reg_multiply_op || (valid && op == slip_pkg::OP_SPECIAL
                   && fn[5:3] == 3'h3) || (valid && op == slip_pkg::OP_SPECIAL
                   && fn[5:3] == 3'h2);
   end
endmodule

// ===== rtl/hazard_space.sv
// counts instructions issued since a hazard producer; clears on a barrier
// assumes issue is a one-cycle pulse per instruction leaving E
`timescale 1ns/1ns
module hazard_space
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       start,
   input  wire logic [2:0] spacing,
   input  wire logic       issue,
   input  wire logic       barrier,
   output logic            pending
);
   logic [2:0] left_reg;

   // countdown of instructions still inside the hazard shadow
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         left_reg <= 3'h0;
      else if (start)
         left_reg <= spacing;
      else if (barrier)
         left_reg <= 3'h0;
      else if (issue && left_reg != 3'h0)
         left_reg <= left_reg - 3'h1;
   end
   assign pending = left_reg != 3'h0;
endmodule

// ===== rtl/slip_control.sv
// slip and interlock control for the I, E, M, A, W pipeline
// assumes the icache, data side and multiply unit report status each cycle
`timescale 1ns/1ns
module slip_control
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        fetch_valid,
   input  wire logic [31:0] fetch_word,
   input  wire logic        icache_miss,
   input  wire logic        icache_fill_valid,
   input  wire logic [31:0] icache_fill_word,
   input  wire logic        xlat_fetch_miss,
   input  wire logic        xlat_data_miss,
   input  wire logic        dcache_hold,
   input  wire logic        fast_multiplier,
   input  wire logic        mul_wide,
   input  wire logic        mdu_busy,
   output logic             adv_i_reg,
   output logic             adv_e_reg,
   output logic             adv_m_reg,
   output logic             adv_a_reg,
   output logic             bubble_m_reg,
   output logic             issue_reg,
   output logic             exec_hazard_reg,
   output logic             instr_hazard_reg,
   output logic             timer_irq_out_reg
);
   slip_pkg::decode_t dec_e;
   slip_pkg::decode_t dec_m;
   slip_pkg::decode_t dec_m_next;
   slip_pkg::decode_t dec_a;
   slip_pkg::advance_t adv;
   logic [31:0] word_e_reg;
   logic        valid_e_reg;
   logic        wait_fill_reg;
   logic [1:0]  slip_cnt_reg;
   logic        mul_last_reg;
   logic [4:0]  mul_dest_reg;
   logic        mdu_prev_reg;
   logic        hold_e;
   logic        hold_m;
   logic        hold_a;
   logic        e_dep;
   logic [1:0]  need;
   logic        issue;
   logic        xlat_pend;
   logic        cache_pend;
   logic        timer_pend;
   logic        sys_pend;
   logic        exec_bar;
   logic        instr_bar;

   // true when the E instruction reads register r
   function automatic logic reads(input slip_pkg::decode_t d,
                                  input logic [4:0] r);
      reads = r != 5'h00 && ((d.rs_used && d.rs == r)
                             || (d.rt_used && d.rt == r));
   endfunction

   insn_decode u_dec_e
   (
      .valid (valid_e_reg),
      .word  (word_e_reg),
      .dec   (dec_e)
   );

   // extra cycles required in E by the instruction ahead in M, or by the last issued fast multiply
   always_comb
   begin
      need = 2'h0;
      e_dep = dec_m.valid && reads(dec_e, dec_m.dest);
      if (dec_m.is_load && e_dep)
         need = slip_pkg::DLY_LOAD;
      else if (dec_m.sysctl_read_op && e_dep)
         need = slip_pkg::DLY_SYSREAD;
      else if (mul_last_reg && dec_e.valid)
      begin
         if (reads(dec_e, mul_dest_reg))
            need = mul_wide ? slip_pkg::DLY_MUL32_C
                            : slip_pkg::DLY_MUL16_C;
         else
            need = mul_wide ? slip_pkg::DLY_MUL32_N
                            : slip_pkg::DLY_MUL16_N;
      end
   end

   // hold terms, latest stage first so its hold wins
   always_comb
   begin
      hold_a = dcache_hold;
      hold_m = hold_a || xlat_data_miss;
      hold_e = hold_m || wait_fill_reg
               || (need != 2'h0 && slip_cnt_reg != need)
               || (!fast_multiplier && dec_e.mdu_op
                   && (mdu_busy || mdu_prev_reg));
      // xlat_write then memory op needs no slip: new entry seen at once
      adv.adv_a = !hold_a;
      adv.adv_m = !hold_m;
      adv.adv_e = !hold_e;
      adv.adv_i = !hold_e && !xlat_fetch_miss;
   end
   // W always drains, so the pipe never halts whole
   assign issue = adv.adv_e && valid_e_reg;

   // slip counter: counts interlock cycles spent waiting in E while M is not held
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         slip_cnt_reg <= 2'h0;
      else if (adv.adv_e || need == 2'h0)
         slip_cnt_reg <= 2'h0;
      else if (!hold_m)
         slip_cnt_reg <= slip_cnt_reg + 2'h1;
   end

   // area multiplier keeps its op pending one cycle after issue
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         mdu_prev_reg <= 1'b0;
      else
         mdu_prev_reg <= issue && dec_e.mdu_op && !fast_multiplier;
   end

   // fast multiply shadow lasts until the next issue or a cycle with E empty; the bubble that
   // follows the multiply into M must not cut the slip short
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         mul_last_reg <= 1'b0;
         mul_dest_reg <= 5'h00;
      end
      else if (issue)
      begin
         mul_last_reg <= dec_e.reg_multiply_op && fast_multiplier;
         mul_dest_reg <= dec_e.dest;
      end
      else if (!valid_e_reg)
         mul_last_reg <= 1'b0;
   end

   // E stage word: filled from fetch, or forwarded from the miss refill
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         word_e_reg <= 32'h0;
         valid_e_reg <= 1'b0;
         wait_fill_reg <= 1'b0;
      end
      else if (wait_fill_reg)
      begin
         if (icache_fill_valid)
         begin
            word_e_reg <= icache_fill_word;
            valid_e_reg <= 1'b1;
            wait_fill_reg <= 1'b0;
         end
      end
      else if (adv.adv_i)
      begin
         word_e_reg <= fetch_word;
         valid_e_reg <= fetch_valid && !icache_miss;
         wait_fill_reg <= fetch_valid && icache_miss;
      end
      else if (adv.adv_e)
         valid_e_reg <= 1'b0;
   end

   // M and A stage decode; a bubble enters M when E holds
   always_comb
   begin
      dec_m_next = dec_e;
      if (!issue)
         dec_m_next = '0;
   end
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         dec_m <= '0;
         dec_a <= '0;
      end
      else
      begin
         if (adv.adv_m)
            dec_m <= dec_m_next;
         if (adv.adv_a)
            dec_a <= adv.adv_m ? dec_m : '0;
      end
   end

   // barrier decode at issue
   assign exec_bar = issue && (dec_e.exec_barrier_op
                               || dec_e.jump_barrier_op);
   assign instr_bar = issue && dec_e.jump_barrier_op;

   // fetch sees new translation after three instructions or a jump barrier
   hazard_space u_xlat
   (
      .clock   (clock),
      .rst     (rst),
      .start   (issue && dec_e.xlat_write_op),
      .spacing (slip_pkg::SP_XLAT_FETCH),
      .issue   (issue),
      .barrier (instr_bar),
      .pending (xlat_pend)
   );
   // cache write of the instruction stream; sync with jump barrier clears
   hazard_space u_cache
   (
      .clock   (clock),
      .rst     (rst),
      .start   (issue && (dec_e.cache_op || dec_e.icache_sync_op)),
      .spacing (slip_pkg::SP_CACHE_FETCH),
      .issue   (issue),
      .barrier (instr_bar),
      .pending (cache_pend)
   );
   // timer clear through compare rewrite
   hazard_space u_timer
   (
      .clock   (clock),
      .rst     (rst),
      .start   (issue && dec_e.timer_clear),
      .spacing (slip_pkg::SP_TIMER),
      .issue   (issue),
      .barrier (exec_bar),
      .pending (timer_pend)
   );
   // other system-control writes; translation reads need no spacing
   hazard_space u_sys
   (
      .clock   (clock),
      .rst     (rst),
      .start   (issue && dec_e.sysctl_write_op && !dec_e.timer_clear),
      .spacing (slip_pkg::SP_SYSWRITE),
      .issue   (issue),
      .barrier (exec_bar),
      .pending (sys_pend)
   );
   // an xlat read retires its entry values before a following system read
   // so the read sees them with zero spacing

   // registered outputs
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         adv_i_reg <= 1'b0;
         adv_e_reg <= 1'b0;
         adv_m_reg <= 1'b0;
         adv_a_reg <= 1'b0;
         bubble_m_reg <= 1'b0;
         issue_reg <= 1'b0;
         exec_hazard_reg <= 1'b0;
         instr_hazard_reg <= 1'b0;
         timer_irq_out_reg <= 1'b0;
      end
      else
      begin
         adv_i_reg <= adv.adv_i;
         adv_e_reg <= adv.adv_e;
         adv_m_reg <= adv.adv_m;
         adv_a_reg <= adv.adv_a;
         bubble_m_reg <= adv.adv_m && !issue;
         issue_reg <= issue;
         exec_hazard_reg <= timer_pend || sys_pend;
         instr_hazard_reg <= xlat_pend || cache_pend;
         timer_irq_out_reg <= timer_pend;
      end
   end

   AST_HOLD_CHAIN: assert property (@(posedge clock) disable iff (rst)
      !adv.adv_m |-> !adv.adv_e && !adv.adv_i)
      else $error("earlier stage advanced past a held stage");
   AST_BACK_DRAINS: assert property (@(posedge clock) disable iff (rst)
      (!adv.adv_e && adv.adv_m) |=> bubble_m_reg)
      else $error("no bubble behind held E");
   AST_LOAD_SLIP: assert property (@(posedge clock) disable iff (rst)
      (dec_m.is_load && reads(dec_e, dec_m.dest) && adv.adv_a
       && !xlat_data_miss && !wait_fill_reg && slip_cnt_reg == 2'h0)
      |-> !issue)
      else $error("load consumer issued without slip");
   AST_MUL_WIDE: assert property (@(posedge clock) disable iff (rst)
      (need == slip_pkg::DLY_MUL32_C && slip_cnt_reg == 2'h0
       && !hold_m && !wait_fill_reg) |-> !issue ##1 !issue)
      else $error("wide multiply consumer issued early");
   AST_FILL_FWD: assert property (@(posedge clock) disable iff (rst)
      (wait_fill_reg && icache_fill_valid) |=> valid_e_reg
      && word_e_reg == $past(icache_fill_word))
      else $error("refill word not forwarded into E");
   AST_FREE_ISSUE: assert property (@(posedge clock) disable iff (rst)
      (valid_e_reg && need == 2'h0 && !hold_m && !wait_fill_reg
       && !(dec_e.mdu_op && !fast_multiplier)) |-> issue)
      else $error("issue blocked with no interlock");
   AST_XLAT_SPACE: assert property (@(posedge clock) disable iff (rst)
      (issue && dec_e.xlat_write_op) |=> xlat_pend)
      else $error("translation fetch hazard not tracked");
   AST_BARRIER: assert property (@(posedge clock) disable iff (rst)
      (exec_bar && !(issue && dec_e.sysctl_write_op)) |=> !sys_pend)
      else $error("barrier did not clear execution hazard");
   AST_SMALL_MDU: assert property (@(posedge clock) disable iff (rst)
      (!fast_multiplier && dec_e.mdu_op && mdu_busy) |-> !issue)
      else $error("mdu op issued while unit busy");
   AST_XLAT_NO_SLIP: assert property (@(posedge clock)
      disable iff (rst)
      (dec_m.xlat_write_op && dec_e.mem_op) |-> need == 2'h0)
      else $error("memory op slipped behind translation write");
   AST_XLAT_READ_FREE: assert property (@(posedge clock)
      disable iff (rst)
      (dec_m.xlat_read_op && dec_e.sysctl_read_op) |-> need == 2'h0)
      else $error("system read slipped behind translation read");
endmodule

// ===== test/slip_far_model.sv
// far side model: instruction cache refill and iterative multiply unit
// assumes the bench arms one miss or one multiply at a time
`timescale 1ns/1ns
module slip_far_model
#(
   parameter int MDU_LAT = 5
)
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        fetch_valid,
   input  wire logic [31:0] fetch_word,
   input  wire logic        miss_arm,
   input  wire logic [2:0]  miss_lat,
   input  wire logic        mdu_arm,
   output logic             icache_miss,
   output logic             icache_fill_valid,
   output logic [31:0]      icache_fill_word,
   output logic             mdu_busy
);
   logic [2:0]  wait_reg;
   logic [31:0] word_reg;
   int          mdu_reg;

   // a miss is only flagged while a word is really being fetched
   assign icache_miss = miss_arm & fetch_valid;

   // refill latency counts from the edge that took the miss
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         wait_reg <= 3'h0;
         word_reg <= 32'h0000_0000;
         mdu_reg  <= 0;
      end
      else
      begin
         if (icache_miss)
         begin
            wait_reg <= miss_lat;
            word_reg <= fetch_word;
         end
         else if (wait_reg != 3'h0)
            wait_reg <= wait_reg - 3'h1;
         if (mdu_arm)
            mdu_reg <= MDU_LAT;
         else if (mdu_reg != 0)
            mdu_reg <= mdu_reg - 1;
      end
   end

   // fill and busy outputs move on the falling edge; an idle refill bus toggles so a
   // stale word can never be mistaken for a refill
   always_ff @(negedge clock or posedge rst)
   begin
      if (rst)
      begin
         icache_fill_valid <= 1'b0;
         icache_fill_word  <= 32'hffff_ffff;
         mdu_busy          <= 1'b0;
      end
      else
      begin
         icache_fill_valid <= wait_reg == 3'h1;
         icache_fill_word  <= wait_reg == 3'h1 ? word_reg : ~icache_fill_word;
         mdu_busy          <= mdu_reg != 0;
      end
   end
endmodule

// ===== test/slip_control_tb_top.sv
// bench for slip_control: short programs, stall and hazard counts
// assumes slip_far_model answers refills and multiply-unit busy
`timescale 1ns/1ns
module slip_control_tb_top;
   localparam logic [31:0] NOP  = 32'h0000_0000;
   localparam logic [31:0] LD   = 32'h8c23_0000; // load into r3
   localparam logic [31:0] USE3 = 32'h0065_2020; // reads r3
   localparam logic [31:0] OTH  = 32'h00e8_3020; // unrelated add
   localparam logic [31:0] SRD  = 32'h4003_6000; // sysctl read to r3
   localparam logic [31:0] PRD  = 32'h7022_1802; // multiply into r3
   localparam logic [31:0] SWR  = 32'h4082_6000; // sysctl write
   localparam logic [31:0] CMPW = 32'h4082_5800; // compare rewrite
   localparam logic [31:0] XW   = 32'h4200_0002; // translation write
   localparam logic [31:0] XR   = 32'h4200_0001; // translation read
   localparam logic [31:0] CAC  = 32'hbc00_0000; // cache maintenance
   localparam logic [31:0] XB   = 32'h0000_00c0; // execution barrier
   localparam logic [31:0] JB   = 32'h03e0_0408; // jump with barrier
   localparam logic [31:0] SYN  = 32'h043f_0000; // icache sync
   localparam int DC   = 99; // not checked
   localparam int SAME = 98; // bubbles equal stall cycles
   localparam int DL   = int'(slip_pkg::DLY_LOAD);
   localparam int DS   = int'(slip_pkg::DLY_SYSREAD);
   logic        clock, rst, fetch_valid, icache_miss, icache_fill_valid;
   logic [31:0] fetch_word, icache_fill_word;
   logic        xlat_fetch_miss, xlat_data_miss, dcache_hold;
   logic        fast_multiplier, mul_wide, mdu_busy, miss_arm, mdu_arm;
   logic        adv_i_reg, adv_e_reg, adv_m_reg, adv_a_reg, bubble_m_reg;
   logic        issue_reg, exec_hazard_reg, instr_hazard_reg;
   logic        timer_irq_out_reg;
   logic [2:0]  miss_lat;
   logic [31:0] prog [0:2];
   int          num_errors, n_tests, seed;

   slip_control dut
   (
      .clock(clock), .rst(rst), .fetch_valid(fetch_valid),
      .fetch_word(fetch_word), .icache_miss(icache_miss),
      .icache_fill_valid(icache_fill_valid),
      .icache_fill_word(icache_fill_word),
      .xlat_fetch_miss(xlat_fetch_miss), .xlat_data_miss(xlat_data_miss),
      .dcache_hold(dcache_hold), .fast_multiplier(fast_multiplier),
      .mul_wide(mul_wide), .mdu_busy(mdu_busy), .adv_i_reg(adv_i_reg),
      .adv_e_reg(adv_e_reg), .adv_m_reg(adv_m_reg), .adv_a_reg(adv_a_reg),
      .bubble_m_reg(bubble_m_reg), .issue_reg(issue_reg),
      .exec_hazard_reg(exec_hazard_reg),
      .instr_hazard_reg(instr_hazard_reg),
      .timer_irq_out_reg(timer_irq_out_reg)
   );

   slip_far_model far
   (
      .clock(clock), .rst(rst), .fetch_valid(fetch_valid),
      .fetch_word(fetch_word), .miss_arm(miss_arm), .miss_lat(miss_lat),
      .mdu_arm(mdu_arm), .icache_miss(icache_miss),
      .icache_fill_valid(icache_fill_valid),
      .icache_fill_word(icache_fill_word), .mdu_busy(mdu_busy)
   );

   // free-running core clock, 10 ns period
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic end_sim;
      $display("mismatches %0d, checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // exp below zero means the count must stay under its magnitude
   task automatic chk_int(input string what, input int got, input int exp);
      if (exp == DC)
         return;
      n_tests++;
      if (exp < 0 ? got >= -exp : got != exp)
      begin
         num_errors++;
         $display("MISMATCH at %0t: %s %0d, model %0d", $time, what, got, exp);
      end
   endtask

   task automatic chk_bits(input logic [8:0] got, input logic [8:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH at %0t: outputs %h, model %h", $time, got, exp);
      end
   endtask

   // a fresh reset per program keeps earlier hazards from leaking in
   task automatic do_reset;
      rst = 1'b1;
      repeat (2) @(negedge clock);
      chk_bits({adv_i_reg, adv_e_reg, adv_m_reg, adv_a_reg, bubble_m_reg,
                issue_reg, exec_hazard_reg, instr_hazard_reg,
                timer_irq_out_reg}, 9'h000);
      rst = 1'b0;
   endtask

   // mode bits: 0 fetch xlat hold, 1 data xlat hold, 2 dcache hold,
   // 3 refill miss on the second word, 4 iterative multiply busy
   task automatic sc(input logic [31:0] w0, w1, w2, input logic [1:0] fw,
                     input int mode, est, ebub, eeh, eih, etm);
      int ptr = 0, iss = 0, st = 0, bub = 0, bad = 0, armed = 0;
      int eh = 0, ih = 0, tm = 0, lat, cyc;
      do_reset();
      prog[0] = w0;
      prog[1] = w1;
      prog[2] = w2;
      {fast_multiplier, mul_wide} = fw;
      lat = 1 + ($unsigned($random(seed)) % 4);
      miss_lat = lat[2:0];
      for (cyc = 0; cyc < 200 && iss < 12; cyc++)
      begin
         if (cyc > 0 && adv_i_reg === 1'b1)
            ptr++;
         fetch_word      = ptr < 3 ? prog[ptr] : NOP;
         miss_arm        = mode[3] && ptr == 1 && armed == 0;
         armed           = armed | miss_arm;
         mdu_arm         = mode[4] && cyc == 0;
         xlat_fetch_miss = mode[0] && (cyc == 8 || cyc == 9);
         xlat_data_miss  = mode[1] && (cyc == 8 || cyc == 9);
         dcache_hold     = mode[2] && (cyc == 8 || cyc == 9);
         @(negedge clock);
         if (issue_reg === 1'b1)
            iss++;
         else if (iss > 0)
            st++;
         bub += (iss > 0 && bubble_m_reg === 1'b1);
         eh  += (exec_hazard_reg === 1'b1);
         ih  += (instr_hazard_reg === 1'b1);
         tm  += (timer_irq_out_reg === 1'b1);
         bad += (adv_a_reg === 1'b0 && adv_m_reg !== 1'b0) ||
                (adv_m_reg === 1'b0 && adv_e_reg !== 1'b0) ||
                (adv_e_reg === 1'b0 && adv_i_reg !== 1'b0);
      end
      {miss_arm, mdu_arm, xlat_fetch_miss, xlat_data_miss, dcache_hold} = 5'h00;
      chk_int("stall", mode[4] ? int'(st != 0) : st, mode[3] ? lat : est);
      chk_int("bubble", bub, ebub == SAME ? st : ebub);
      chk_int("order", bad, 0);
      chk_int("exec hazard", eh, eeh);
      chk_int("fetch hazard", ih, eih);
      chk_int("timer", tm, etm);
      // a hung program ends the run at once, after its counts are reported
      if (iss < 12)
      begin
         num_errors++;
         $display("MISMATCH at %0t: issue stuck at %0d", $time, iss);
         end_sim();
      end
   endtask

   // programs are followed by no-ops; every input is set at time zero
   initial
   begin
      seed = 78413;
      num_errors = 0;
      n_tests = 0;
      rst = 1'b1;
      fetch_valid = 1'b1;
      fetch_word = NOP;
      {miss_arm, mdu_arm, xlat_fetch_miss, xlat_data_miss, dcache_hold} = 5'h00;
      {fast_multiplier, mul_wide} = 2'b10;
      miss_lat = 3'h1;
      repeat (8) @(negedge clock);
      sc(NOP, NOP, NOP, 2'b10, 0, 0, 0, 0, 0, 0);
      sc(LD, USE3, NOP, 2'b10, 0, DL, SAME, DC, DC, DC);
      sc(SRD, USE3, NOP, 2'b10, 0, DS, SAME, DC, DC, DC);
      sc(PRD, USE3, NOP, 2'b10, 0, 2, SAME, DC, DC, DC);
      sc(PRD, USE3, NOP, 2'b11, 0, 3, SAME, DC, DC, DC);
      sc(PRD, OTH, NOP, 2'b10, 0, 1, SAME, DC, DC, DC);
      sc(PRD, OTH, NOP, 2'b11, 0, 2, SAME, DC, DC, DC);
      sc(PRD, PRD, NOP, 2'b00, 16, 1, SAME, DC, DC, DC);
      sc(NOP, OTH, NOP, 2'b10, 8, 0, SAME, DC, DC, DC);
      sc(SWR, NOP, NOP, 2'b10, 0, 0, 0, 2, DC, DC);
      sc(CMPW, NOP, NOP, 2'b10, 0, 0, 0, DC, DC, 4);
      sc(XW, NOP, NOP, 2'b10, 0, 0, 0, DC, 3, DC);
      sc(CAC, NOP, NOP, 2'b10, 0, 0, 0, DC, 3, DC);
      sc(SWR, XB, NOP, 2'b10, 0, 0, 0, -2, DC, DC);
      sc(XW, JB, NOP, 2'b10, 0, 0, 0, DC, -3, DC);
      sc(CAC, SYN, JB, 2'b10, 0, 0, 0, DC, -3, DC);
      sc(XW, LD, NOP, 2'b10, 0, 0, 0, DC, 3, DC);
      sc(XR, SRD, NOP, 2'b10, 0, 0, 0, DC, DC, DC);
      sc(NOP, NOP, NOP, 2'b10, 1, 2, 2, DC, DC, DC);
      sc(NOP, NOP, NOP, 2'b10, 2, 2, 0, DC, DC, DC);
      sc(NOP, NOP, NOP, 2'b10, 4, 2, 0, DC, DC, DC);
      end_sim();
   end
endmodule
